// ===== rtl/vpiu_pkg.sv
/*
 vectored priority interrupt unit: shared constants and types.
 assumes a 32-bit apb register bus and a single system clock.
*/
package vpiu_pkg;
	// fixed handler addresses
	localparam logic [31:0] VEC_BUS = 32'h0000_0008;
	localparam logic [31:0] VEC_TICK = 32'h0000_000e;
	localparam logic [31:0] VEC_ALIGN = 32'h0000_0014;
	localparam logic [31:0] VEC_ILL = 32'h0000_001a;
	localparam logic [31:0] VEC_HW = 32'h0000_0020;
	localparam logic [31:0] VEC_SYS = 32'h0000_0026;
	localparam logic [31:0] VEC_TRAP = 32'h0000_002c;
	localparam logic [31:0] VEC_RST = 32'h0000_0038;
	localparam logic [31:0] VEC_STK = 32'h0000_003e;
	// source count and level width
	localparam int NSRC = 16;
	localparam int LVLW = 4;
	localparam int STKD = 16;
	localparam logic [3:0] LVL_OFF = 4'h0;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SLIM = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_PRLO = 8'h10;
	localparam logic [7:0] REG_PRHI = 8'h14;
	localparam logic [7:0] REG_STATE = 8'h18;
	// control fields
	localparam int CTRL_STK_EN = 0;
	localparam int CTRL_WAKE_PC = 1;
	localparam int CTRL_WAKE_WT = 2;
	localparam int CTRL_WAKE_CMP = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// source slots: 0..7 pins, then always-on peripherals
	localparam logic [15:0] WAKE_PINS = 16'h00ff;
	localparam int SRC_PC = 8;
	localparam int SRC_WT = 9;
	localparam int SRC_CMP = 10;
	// access sizes
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// one cpu data access as seen by the unit
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [1:0] addr_lo;
		logic unmapped;
		logic periph_off;
		logic rom;
	} vpiu_mem_t;
	// saved context of one service level
	typedef struct packed {
		logic sup;
		logic [3:0] lvl;
	} vpiu_stk_t;
endpackage

// ===== rtl/vpiu_top.sv
/*
 vectored priority interrupt unit: exception vectoring, priority
 controller with nesting, apb register file and sleep wake path.
 assumes cpu event inputs are synchronous one-cycle pulses on pclk
 and peripheral request lines are asynchronous levels.
*/
// Added by the designer: the address map and the APB register port.
// Contract
// - taken event loads pc with its vector
// - every entry switches to supervisor mode
// - bad address, off peripheral, rom write vector 0x08
// - tick timer vectors to 0x0e
// - misaligned half or word vectors 0x14
// - unknown encoding vectors to 0x1a
// - system call instruction vectors to 0x26
// - trap instruction or debug vectors 0x2c
// - any reset starts at 0x38
// - enabled stack limit hit vectors 0x3e
// - per-source mask, unmasked requests vector 0x20
// - level per source, zero never interrupts
// - sources may share a level
// - only strictly higher level preempts
// - lower pending served after return
// - pin sources wake in sleep; always-on sources wake only once their ctrl wake enable is set
`timescale 1ns/1ps
`default_nettype none
module vpiu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire vpiu_pkg::vpiu_mem_t mem_i,
	input wire logic ill_instr_i,
	input wire logic sys_instr_i,
	input wire logic trap_instr_i,
	input wire logic debug_trap_i,
	input wire logic tick_i,
	input wire logic soft_rst_i,
	input wire logic sp_valid_i,
	input wire logic [31:0] sp_i,
	input wire logic isr_ret_i,
	input wire logic user_mode_i,
	input wire logic [15:0] src_i,
	output logic pc_load_o,
	output logic [31:0] pc_vec_o,
	output logic supervisor_o,
	output logic irq_o,
	output logic wake_o
);
	// three-stage synchroniser on request lines
	logic [15:0] s1_ff, s2_ff, s3_ff, st_ff;
	// settled level changes only when stages two and three agree
	wire [15:0] agree = ~(s2_ff ^ s3_ff);
	wire [15:0] nxt_st = (agree & s3_ff) | (~agree & st_ff);
	wire [15:0] src_rise = nxt_st & ~st_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_ff <= 16'h0000;
			s2_ff <= 16'h0000;
			s3_ff <= 16'h0000;
			st_ff <= 16'h0000;
		end
		else
		begin
			s1_ff <= src_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			st_ff <= nxt_st;
		end
	end

	// software registers
	logic [3:0] ctrl_ff; // stack check and optional wake enables
	logic [31:0] slim_ff; // stack limit address
	logic [15:0] mask_ff; // 1 lets a source through
	logic [15:0] pend_ff; // sticky request bits
	logic [63:0] prio_ff; // four bits of level per source
	logic [31:0] prdata_ff;

	// apb decode
	wire setup = psel & ~penable;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire hit_ctrl = paddr == vpiu_pkg::REG_CTRL;
	wire hit_slim = paddr == vpiu_pkg::REG_SLIM;
	wire hit_mask = paddr == vpiu_pkg::REG_MASK;
	wire hit_stat = paddr == vpiu_pkg::REG_STAT;
	wire hit_prlo = paddr == vpiu_pkg::REG_PRLO;
	wire hit_prhi = paddr == vpiu_pkg::REG_PRHI;
	wire hit_state = paddr == vpiu_pkg::REG_STATE;
	wire hit = hit_ctrl | hit_slim | hit_mask | hit_stat | hit_prlo
		| hit_prhi | hit_state;
	// zero wait states; unmapped access answers with an error
	assign pready = acc;
	assign pslverr = acc & ~hit;
	assign prdata = prdata_ff;

	// nesting state
	vpiu_pkg::vpiu_stk_t stk_mem [vpiu_pkg::STKD];
	logic [4:0] depth_ff; // 0..16 saved contexts
	logic [3:0] act_ff; // level now being served
	logic sup_ff;
	logic pc_load_ff;
	logic [31:0] pc_vec_ff;
	logic rst_pend_ff; // reset vector owed after release
	logic stk_hit_ff; // previous stack compare, for edge

	// read mux, captured in setup so prdata is a flop
	wire [31:0] rdmux =
		hit_ctrl ? {28'h0000000, ctrl_ff} :
		hit_slim ? slim_ff :
		hit_mask ? {16'h0000, mask_ff} :
		hit_stat ? {16'h0000, pend_ff} :
		hit_prlo ? prio_ff[31:0] :
		hit_prhi ? prio_ff[63:32] :
		hit_state ? {23'h000000, depth_ff, act_ff} :
		32'h0000_0000;

	// read clears only the bits that were returned, so an event
	// landing after the setup snapshot survives
	wire [15:0] pend_clr = (rd & hit_stat) ? prdata_ff[15:0] :
		16'h0000;
	// set wins over clear
	wire [15:0] nxt_pend = (pend_ff & ~pend_clr) | src_rise;

	// apb write and read capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= vpiu_pkg::CTRL_RST;
			slim_ff <= 32'h0000_0000;
			mask_ff <= 16'h0000;
			prio_ff <= 64'h0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			if (wr && hit_ctrl)
				ctrl_ff <= pwdata[3:0];
			if (wr && hit_slim)
				slim_ff <= pwdata;
			if (wr && hit_mask)
				mask_ff <= pwdata[15:0];
			if (wr && hit_prlo)
				prio_ff[31:0] <= pwdata;
			if (wr && hit_prhi)
				prio_ff[63:32] <= pwdata;
			if (setup)
				prdata_ff <= rdmux;
		end
	end

	// pending bits, sticky until status read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_ff <= 16'h0000;
		else
			pend_ff <= nxt_pend;
	end

	// highest level among live sources; shared levels just merge
	logic [3:0] best_lvl;
	always_comb
	begin
		best_lvl = vpiu_pkg::LVL_OFF;
		for (int i = 0; i < vpiu_pkg::NSRC; i++)
		begin
			// level zero never wins since best starts at zero
			if (pend_ff[i] && mask_ff[i] &&
				prio_ff[i*4 +: 4] > best_lvl)
				best_lvl = prio_ff[i*4 +: 4];
		end
	end

	// strictly higher than current level only
	wire hw_req = best_lvl > act_ff;
	// level output to the cpu follows the same gate
	assign irq_o = hw_req;

	// cpu exception causes
	wire misal = (mem_i.size == vpiu_pkg::SZ_HALF &&
		mem_i.addr_lo[0]) ||
		(mem_i.size == vpiu_pkg::SZ_WORD && mem_i.addr_lo != 2'h0);
	wire c_bus = mem_i.req & (mem_i.unmapped | mem_i.periph_off |
		(mem_i.we & mem_i.rom));
	wire c_align = mem_i.req & misal;
	// stack grows down, so at or below the limit is overflow
	wire stk_hit = ctrl_ff[vpiu_pkg::CTRL_STK_EN] & sp_valid_i &
		(sp_i <= slim_ff);
	wire c_stk = stk_hit & ~stk_hit_ff;
	wire c_trap = trap_instr_i | debug_trap_i;
	wire c_rst = rst_pend_ff | soft_rst_i;
	wire exc = c_rst | c_bus | c_align | ill_instr_i | sys_instr_i
		| c_trap | c_stk | tick_i;
	wire take = exc | hw_req;

	// fixed priority among simultaneous causes
	wire [31:0] vec =
		c_rst ? vpiu_pkg::VEC_RST :
		c_bus ? vpiu_pkg::VEC_BUS :
		c_align ? vpiu_pkg::VEC_ALIGN :
		ill_instr_i ? vpiu_pkg::VEC_ILL :
		sys_instr_i ? vpiu_pkg::VEC_SYS :
		c_trap ? vpiu_pkg::VEC_TRAP :
		c_stk ? vpiu_pkg::VEC_STK :
		tick_i ? vpiu_pkg::VEC_TICK :
		vpiu_pkg::VEC_HW;
	wire hw_take = take & ~exc;
	wire push = take & ~c_rst & (depth_ff != 5'(vpiu_pkg::STKD));
	// a return in the entry cycle is dropped; entry wins
	wire pop = isr_ret_i & ~take & (depth_ff != 5'h00);
	wire [3:0] top_idx = 4'(depth_ff - 5'h01);
	vpiu_pkg::vpiu_stk_t top;
	assign top = stk_mem[top_idx];

	// save context on entry, reload on return
	always_ff @(posedge pclk)
	begin
		if (push)
			stk_mem[depth_ff[3:0]] <= '{sup: sup_ff, lvl: act_ff};
	end

	// entry, nesting and mode control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_pend_ff <= 1'b1;
			depth_ff <= 5'h00;
			act_ff <= vpiu_pkg::LVL_OFF;
			sup_ff <= 1'b1;
			pc_load_ff <= 1'b0;
			pc_vec_ff <= vpiu_pkg::VEC_RST;
			stk_hit_ff <= 1'b0;
		end
		else
		begin
			rst_pend_ff <= 1'b0;
			stk_hit_ff <= stk_hit;
			pc_load_ff <= take;
			if (take)
				pc_vec_ff <= vec;
			if (c_rst)
			begin
				// reset drops all nesting
				depth_ff <= 5'h00;
				act_ff <= vpiu_pkg::LVL_OFF;
				sup_ff <= 1'b1;
			end
			else if (take)
			begin
				sup_ff <= 1'b1;
				if (push)
					depth_ff <= depth_ff + 5'h01;
				if (hw_take)
					act_ff <= best_lvl;
			end
			else if (pop)
			begin
				depth_ff <= depth_ff - 5'h01;
				act_ff <= top.lvl;
				sup_ff <= top.sup;
			end
			else if (user_mode_i)
				sup_ff <= 1'b0;
		end
	end

	assign pc_load_o = pc_load_ff;
	assign pc_vec_o = pc_vec_ff;
	assign supervisor_o = sup_ff;

	// wake path is combinational on raw pins: clock may be stopped
	wire [15:0] wake_en = vpiu_pkg::WAKE_PINS |
		(16'(ctrl_ff[vpiu_pkg::CTRL_WAKE_PC]) << vpiu_pkg::SRC_PC) |
		(16'(ctrl_ff[vpiu_pkg::CTRL_WAKE_WT]) << vpiu_pkg::SRC_WT) |
		(16'(ctrl_ff[vpiu_pkg::CTRL_WAKE_CMP]) << vpiu_pkg::SRC_CMP);
	assign wake_o = |(src_i & wake_en);

	// checks
	chk_entry_load: assert property (@(posedge pclk)
		disable iff (!presetn) take |=> pc_load_o && pc_vec_o == $past(vec))
		else $error("entry did not load vector");
	chk_sup_entry: assert property (@(posedge pclk)
		disable iff (!presetn) pc_load_o |-> supervisor_o)
		else $error("handler not in supervisor mode");
	chk_bus_vec: assert property (@(posedge pclk)
		disable iff (!presetn) c_bus && !c_rst |=>
		pc_vec_o == vpiu_pkg::VEC_BUS)
		else $error("bus error vector wrong");
	chk_align_vec: assert property (@(posedge pclk)
		disable iff (!presetn) mem_i.req && misal && !c_bus && !c_rst
		|=> pc_vec_o == vpiu_pkg::VEC_ALIGN)
		else $error("alignment vector wrong");
	chk_soft_rst: assert property (@(posedge pclk)
		disable iff (!presetn) soft_rst_i |=>
		pc_vec_o == vpiu_pkg::VEC_RST && depth_ff == 5'h00)
		else $error("reset vector wrong");
	chk_lvl_zero: assert property (@(posedge pclk)
		disable iff (!presetn) pc_load_o && pc_vec_o == vpiu_pkg::VEC_HW
		|-> $past(best_lvl) != vpiu_pkg::LVL_OFF)
		else $error("level zero interrupted");
	chk_preempt: assert property (@(posedge pclk)
		disable iff (!presetn) hw_take |=>
		act_ff > $past(act_ff) ##1 !(pc_vec_o == vpiu_pkg::VEC_HW &&
		pc_load_o && $past(best_lvl) <= $past(act_ff, 2)))
		else $error("preemption not strictly higher");
	chk_level_pop: assert property (@(posedge pclk)
		disable iff (!presetn) pop |=>
		act_ff == $past(top.lvl) && depth_ff == $past(depth_ff) - 5'h01)
		else $error("return did not restore level");
	chk_stk_vec: assert property (@(posedge pclk)
		disable iff (!presetn) c_stk && vec == vpiu_pkg::VEC_STK |=>
		pc_load_o ##1 !(pc_load_o && pc_vec_o == vpiu_pkg::VEC_STK))
		else $error("stack overflow vector wrong");
	chk_mask_gate: assert property (@(posedge pclk)
		disable iff (!presetn) irq_o |-> |(pend_ff & mask_ff))
		else $error("masked source raised interrupt");

	// causes that outrank each exception, in the order of the vector
	// select; written apart from it so a slip in that chain shows up
	wire above_ill = c_rst | c_bus | c_align;
	wire above_sys = above_ill | ill_instr_i;
	wire above_trap = above_sys | sys_instr_i;
	wire above_tick = above_trap | c_trap | c_stk;

	chk_ill_vec: assert property (@(posedge pclk)
		disable iff (!presetn) ill_instr_i && !above_ill |=>
		pc_load_o && pc_vec_o == vpiu_pkg::VEC_ILL)
		else $error("illegal instruction vector wrong");
	chk_sys_vec: assert property (@(posedge pclk)
		disable iff (!presetn) sys_instr_i && !above_sys |=>
		pc_load_o && pc_vec_o == vpiu_pkg::VEC_SYS)
		else $error("system call vector wrong");
	chk_trap_vec: assert property (@(posedge pclk)
		disable iff (!presetn) (trap_instr_i || debug_trap_i) &&
		!above_trap |=> pc_load_o && pc_vec_o == vpiu_pkg::VEC_TRAP)
		else $error("trap vector wrong");
	chk_tick_vec: assert property (@(posedge pclk)
		disable iff (!presetn) tick_i && !above_tick |=>
		pc_load_o && pc_vec_o == vpiu_pkg::VEC_TICK)
		else $error("tick vector wrong");
	chk_hw_vec: assert property (@(posedge pclk)
		disable iff (!presetn) hw_req && !exc |=>
		pc_load_o && pc_vec_o == vpiu_pkg::VEC_HW)
		else $error("hardware interrupt vector wrong");
	chk_hw_strict: assert property (@(posedge pclk)
		disable iff (!presetn) pc_load_o && pc_vec_o == vpiu_pkg::VEC_HW
		|-> $past(best_lvl) > $past(act_ff))
		else $error("interrupt taken without higher level");
	// first edge out of reset must hand the reset vector over
	chk_rst_release: assert property (@(posedge pclk)
		disable iff (!presetn) rst_pend_ff |=>
		pc_load_o && pc_vec_o == vpiu_pkg::VEC_RST && supervisor_o)
		else $error("reset vector not loaded after release");
	// pins wake without any register setup
	chk_wake_pins: assert property (@(posedge pclk)
		disable iff (!presetn) |(src_i & vpiu_pkg::WAKE_PINS) |-> wake_o)
		else $error("pin request did not wake");
	chk_ret_mode: assert property (@(posedge pclk)
		disable iff (!presetn) pop |=> supervisor_o == $past(top.sup))
		else $error("return did not restore mode");
endmodule
`default_nettype wire

// ===== dv/vpiu_cpu_model.sv
/*
 cpu core stand-in for the interrupt unit: keeps a program counter.
 assumes load pulses and vectors come from the unit on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module vpiu_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pc_load,
	input wire logic [31:0] pc_vec,
	output logic [31:0] pc,
	output logic [31:0] n_loads
);
	// core is stalled outside vectoring, so pc only moves on a load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc <= 32'h0000_0000;
			n_loads <= 32'h0000_0000;
		end
		else if (pc_load)
		begin
			pc <= pc_vec;
			n_loads <= n_loads + 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

// ===== dv/vectored_priority_interrupt_unit_tb.sv
/*
 self-checking bench for the interrupt unit: exception rows, priority
 nesting, apb registers. assumes the hand-over timing of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_unit_tb;
	typedef struct packed {
		logic [7:0] ev;
		logic [8:0] mem;
		logic [31:0] vec;
	} vpiu_row_t;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, cpu_pc, n_loads, base;
	logic pready, pslverr, err, pc_load_o, supervisor_o, irq_o, wake_o;
	logic [31:0] pc_vec_o;
	vpiu_pkg::vpiu_mem_t mem_i = '0;
	logic [7:0] ev = 8'h00; // ill sys trap dbg tick rst user ret
	logic sp_valid = 1'b0;
	logic [31:0] sp_i = 32'h0000_ffff;
	logic [15:0] src_i = 16'h0000;
	int error_cnt = 0, n_checks = 0;
	vpiu_row_t rows [11];
	always #4 pclk = ~pclk;
	vpiu_top vpiu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_i(mem_i), .ill_instr_i(ev[0]),
		.sys_instr_i(ev[1]), .trap_instr_i(ev[2]), .debug_trap_i(ev[3]),
		.tick_i(ev[4]), .soft_rst_i(ev[5]), .sp_valid_i(sp_valid),
		.sp_i(sp_i), .isr_ret_i(ev[7]), .user_mode_i(ev[6]),
		.src_i(src_i), .pc_load_o(pc_load_o), .pc_vec_o(pc_vec_o),
		.supervisor_o(supervisor_o), .irq_o(irq_o), .wake_o(wake_o));
	vpiu_cpu_model vpiu_cpu_model_i (.pclk(pclk), .presetn(presetn),
		.pc_load(pc_load_o), .pc_vec(pc_vec_o), .pc(cpu_pc),
		.n_loads(n_loads));
	// one comparison, counted either way
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// apb transfer; waits for pready, no fixed wait count assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one-cycle event pulse plus optional data access
	task fire(input logic [7:0] e, input logic [8:0] m);
		@(posedge pclk);
		ev <= e;
		mem_i <= vpiu_pkg::vpiu_mem_t'(m);
		@(posedge pclk);
		ev <= 8'h00;
		mem_i <= '0;
	endtask
	// bounded wait for a vector load, then vector and mode
	task wait_load(input logic [31:0] v);
		int k;
		k = 0;
		#1;
		while (pc_load_o !== 1'b1 && k < 12)
		begin
			@(posedge pclk);
			#1;
			k++;
		end
		chk(pc_load_o, 1'b1);
		chk(pc_vec_o, v);
		chk(supervisor_o, 1'b1);
		@(posedge pclk);
		#1;
		chk(cpu_pc, v);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog: whole run is a few hundred cycles
	initial
	begin
		#100000;
		error_cnt++;
		finish_test;
	end
	initial
	begin
		rows = '{
			'{8'h01, 9'h000, vpiu_pkg::VEC_ILL},
			'{8'h02, 9'h000, vpiu_pkg::VEC_SYS},
			'{8'h04, 9'h000, vpiu_pkg::VEC_TRAP},
			'{8'h08, 9'h000, vpiu_pkg::VEC_TRAP},
			'{8'h10, 9'h000, vpiu_pkg::VEC_TICK},
			'{8'h00, 9'h144, vpiu_pkg::VEC_BUS},
			'{8'h00, 9'h142, vpiu_pkg::VEC_BUS},
			'{8'h00, 9'h1c1, vpiu_pkg::VEC_BUS},
			'{8'h00, 9'h128, vpiu_pkg::VEC_ALIGN},
			'{8'h00, 9'h158, vpiu_pkg::VEC_ALIGN},
			'{8'h20, 9'h000, vpiu_pkg::VEC_RST}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_load(vpiu_pkg::VEC_RST);
		// each row: drop to user, raise, check entry, return
		foreach (rows[i])
		begin
			fire(8'h40, 9'h000);
			#1;
			chk(supervisor_o, 1'b0);
			fire(rows[i].ev, rows[i].mem);
			wait_load(rows[i].vec);
			fire(8'h80, 9'h000);
		end
		// aligned half access must not vector
		base = n_loads;
		fire(8'h00, 9'h130);
		repeat (6) @(posedge pclk);
		chk(n_loads, base);
		// stack limit reached with checking on
		apb(1'b1, vpiu_pkg::REG_SLIM, 32'h0000_0100);
		apb(1'b1, vpiu_pkg::REG_CTRL, 32'h0000_0001);
		@(posedge pclk);
		sp_valid <= 1'b1;
		sp_i <= 32'h0000_0080;
		wait_load(vpiu_pkg::VEC_STK);
		apb(1'b1, vpiu_pkg::REG_CTRL, 32'h0000_0000);
		sp_valid <= 1'b0;
		fire(8'h80, 9'h000);
		// wake: pulse counter only once its enable is set
		src_i <= 16'h0100;
		repeat (2) @(posedge pclk);
		chk(wake_o, 1'b0);
		apb(1'b1, vpiu_pkg::REG_CTRL, 32'h0000_0002);
		#1;
		chk(wake_o, 1'b1);
		apb(1'b1, vpiu_pkg::REG_CTRL, 32'h0000_0000);
		// levels: src0 0, src1 5, src2 9, src3 5, src4 7 masked
		apb(1'b1, vpiu_pkg::REG_PRLO, 32'h0007_5950);
		apb(1'b1, vpiu_pkg::REG_MASK, 32'h0000_000f);
		src_i <= 16'h0011;
		repeat (8) @(posedge pclk);
		chk(irq_o, 1'b0);
		chk(wake_o, 1'b1);
		src_i <= 16'h0013;
		wait_load(vpiu_pkg::VEC_HW);
		apb(1'b0, vpiu_pkg::REG_STATE, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0005);
		apb(1'b0, vpiu_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0003);
		apb(1'b0, vpiu_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0000);
		// strictly higher level preempts
		src_i <= 16'h0017;
		wait_load(vpiu_pkg::VEC_HW);
		apb(1'b0, vpiu_pkg::REG_STATE, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0009);
		apb(1'b0, vpiu_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0004);
		// shared level 5 stays quiet until both levels return
		src_i <= 16'h001f;
		repeat (8) @(posedge pclk);
		chk(irq_o, 1'b0);
		fire(8'h80, 9'h000);
		repeat (2) @(posedge pclk);
		chk(irq_o, 1'b0);
		apb(1'b0, vpiu_pkg::REG_STATE, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_0005);
		fire(8'h80, 9'h000);
		wait_load(vpiu_pkg::VEC_HW);
		// hardware reset mid-run: reset vector again, nesting dropped
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(pc_load_o, 1'b0);
		chk(pc_vec_o, vpiu_pkg::VEC_RST);
		chk(irq_o, 1'b0);
		presetn <= 1'b1;
		wait_load(vpiu_pkg::VEC_RST);
		apb(1'b0, vpiu_pkg::REG_STATE, 32'h0);
		chk(rd, 32'h0000_0000);
		// unmapped register is refused
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		finish_test;
	end
endmodule
`default_nettype wire
